//--- verilog/root_hub_port_status_upper.sv
// Purpose: Upper half of the per-port root hub status word, two ports, AXI4-Lite
// Assumes: Attach, speed and overload arrive on pins; other events are same-clock
// Notes:   Change flags double as interrupt status; per-port mask words gate irq
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module root_hub_port_status_upper #(
	parameter int NPORT  = 2,
	parameter int ADDR_W = 8
) (
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [ADDR_W-1:0]        s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic                     host_reset_state,
	input  wire hub_port_pkg::port_pins_s port_pins [NPORT],
	input  wire hub_port_pkg::port_evt_s  port_evt [NPORT],
	output logic [NPORT-1:0]              port_power_on,
	output logic [hub_port_pkg::CMD_W-1:0] lower_cmd [NPORT],
	output logic                          irq
);
	// Address of a port or mask word
	function automatic logic [7:0] word_ofs(input logic [7:0] base, input int p);
		word_ofs = base + 8'(p) * hub_port_pkg::OFS_STEP;
	endfunction

	// Byte strobes widened to a bit mask
	function automatic logic [31:0] strb_bits(input logic [3:0] s);
		strb_bits = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// Synchroniser and edge history for pin inputs
	hub_port_pkg::port_pins_s sync1_r [NPORT];
	hub_port_pkg::port_pins_s sync2_r [NPORT];
	hub_port_pkg::port_pins_s prev_r  [NPORT];

	// Write channel state
	logic              aw_held_r, aw_held_nxt;
	logic              w_held_r, w_held_nxt;
	logic [7:0]        waddr_r, waddr_nxt;
	logic [31:0]       wdata_r, wdata_nxt;
	logic [3:0]        wstrb_r, wstrb_nxt;
	logic              bvalid_r, bvalid_nxt;
	logic [1:0]        bresp_r, bresp_nxt;
	logic              wr_fire;
	logic [31:0]       wmask;

	// Read channel state
	logic              rvalid_r, rvalid_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic [1:0]        rresp_r, rresp_nxt;

	// Port and hub state
	logic              power_r [NPORT];
	logic              power_nxt [NPORT];
	logic [hub_port_pkg::CHG_W-1:0] chg_r [NPORT];
	logic [hub_port_pkg::CHG_W-1:0] chg_nxt [NPORT];
	logic [hub_port_pkg::CHG_W-1:0] mask_r [NPORT];
	logic [hub_port_pkg::CHG_W-1:0] mask_nxt [NPORT];
	logic [hub_port_pkg::CMD_W-1:0] cmd_r [NPORT];
	logic [hub_port_pkg::CMD_W-1:0] cmd_nxt [NPORT];
	logic [hub_port_pkg::CFG_W-1:0] cfg_r, cfg_nxt;
	logic [31:0]       port_w [NPORT];
	logic [31:0]       word_v [NPORT];
	logic [hub_port_pkg::CHG_W-1:0] evt_v [NPORT];
	logic              always_on;

	// Two-stage pin synchroniser; only stage two feeds logic
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_r <= '{default: '0};
			sync2_r <= '{default: '0};
			prev_r  <= '{default: '0};
		end else begin
			sync1_r <= port_pins;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready  = !w_held_r && !bvalid_r;
	assign wr_fire       = aw_held_r && w_held_r && !bvalid_r;
	assign wmask         = wdata_r & strb_bits(wstrb_r); // Strobed-off bytes act as zero

	always_comb begin
		logic hit;
		hit         = 1'b0;
		aw_held_nxt = aw_held_r;
		w_held_nxt  = w_held_r;
		waddr_nxt   = waddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_nxt = 1'b1;
			waddr_nxt   = 8'(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb_nxt  = s_axi_wstrb;
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (wr_fire) begin
			hit = (waddr_r == hub_port_pkg::OFS_CFG);
			for (int p = 0; p < NPORT; p++) begin
				hit = hit || (waddr_r == word_ofs(hub_port_pkg::OFS_PORT_BASE, p));
				hit = hit || (waddr_r == word_ofs(hub_port_pkg::OFS_MASK_BASE, p));
			end
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = hit ? hub_port_pkg::RESP_OKAY : hub_port_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			waddr_r   <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= 2'h0;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r  <= w_held_nxt;
			waddr_r   <= waddr_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	// Visible port words and hardware events
	assign always_on = cfg_r[hub_port_pkg::CFG_ALWAYS_ON];
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			word_v[p] = hub_port_pkg::WORD_RST;
			word_v[p][hub_port_pkg::B_ATTACH] = sync2_r[p].attached
				|| cfg_r[hub_port_pkg::CFG_FIXED_LSB + p];
			word_v[p][hub_port_pkg::B_LOW_MSB:hub_port_pkg::B_LOW_LSB] = port_evt[p].lower;
			word_v[p][hub_port_pkg::B_PWR] = power_r[p] || always_on;
			word_v[p][hub_port_pkg::B_SLOW] = sync2_r[p].slow && sync2_r[p].attached;
			word_v[p][hub_port_pkg::B_CHG_MSB:hub_port_pkg::B_CHG_LSB] = chg_r[p];
			evt_v[p] = '0;
			evt_v[p][hub_port_pkg::C_ATTACH]   = sync2_r[p].attached != prev_r[p].attached;
			evt_v[p][hub_port_pkg::C_EN_DROP]  = port_evt[p].enable_drop;
			evt_v[p][hub_port_pkg::C_RESUME]   = port_evt[p].resume_done;
			evt_v[p][hub_port_pkg::C_OVL]      = sync2_r[p].overload != prev_r[p].overload;
			evt_v[p][hub_port_pkg::C_RST_DONE] = port_evt[p].reset_done;
			port_w[p] = (wr_fire && waddr_r == word_ofs(hub_port_pkg::OFS_PORT_BASE, p))
				? (wmask & ~hub_port_pkg::PORT_RSVD) : 32'h0000_0000;
		end
	end

	// Port state: change events beat clears, power clear beats power set, host reset beats all but mask and cfg writes
	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_fire && waddr_r == hub_port_pkg::OFS_CFG)
			cfg_nxt = wmask[hub_port_pkg::CFG_W-1:0];
		for (int p = 0; p < NPORT; p++) begin
			power_nxt[p] = power_r[p];
			if (port_w[p][hub_port_pkg::B_PWR])
				power_nxt[p] = 1'b1;
			if (port_w[p][hub_port_pkg::B_PWR_CLR])
				power_nxt[p] = 1'b0;
			chg_nxt[p] = (chg_r[p]
				& ~port_w[p][hub_port_pkg::B_CHG_MSB:hub_port_pkg::B_CHG_LSB])
				| evt_v[p];
			cmd_nxt[p] = port_w[p][hub_port_pkg::CMD_W-1:0];
			mask_nxt[p] = mask_r[p];
			if (wr_fire && waddr_r == word_ofs(hub_port_pkg::OFS_MASK_BASE, p))
				mask_nxt[p] = wmask[hub_port_pkg::B_CHG_MSB:hub_port_pkg::B_CHG_LSB];
			if (host_reset_state) begin
				power_nxt[p] = 1'b0;
				chg_nxt[p]   = '0;
				chg_nxt[p][hub_port_pkg::C_ATTACH] = cfg_r[hub_port_pkg::CFG_FIXED_LSB + p];
				cmd_nxt[p]   = '0;
			end
		end
	end

	// Async reset leaves cfg clear, so attach change starts at zero here
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_r   <= '0;
			power_r <= '{default: 1'b0};
			chg_r   <= '{default: '0};
			mask_r  <= '{default: '0};
			cmd_r   <= '{default: '0};
		end else begin
			cfg_r   <= cfg_nxt;
			power_r <= power_nxt;
			chg_r   <= chg_nxt;
			mask_r  <= mask_nxt;
			cmd_r   <= cmd_nxt;
		end
	end

	// Outputs and interrupt level
	always_comb begin
		irq = 1'b0;
		for (int p = 0; p < NPORT; p++) begin
			port_power_on[p] = power_r[p] || always_on;
			lower_cmd[p]     = cmd_r[p];
			irq              = irq || |(chg_r[p] & mask_r[p]);
		end
	end

	// Read channel: one cycle from address to data
	assign s_axi_arready = !rvalid_r;
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = 32'h0000_0000;
			rresp_nxt  = hub_port_pkg::RESP_SLVERR;
			if (8'(s_axi_araddr) == hub_port_pkg::OFS_CFG) begin
				rdata_nxt[hub_port_pkg::CFG_W-1:0] = cfg_r;
				rresp_nxt = hub_port_pkg::RESP_OKAY;
			end
			for (int p = 0; p < NPORT; p++) begin
				if (8'(s_axi_araddr) == word_ofs(hub_port_pkg::OFS_PORT_BASE, p)) begin
					rdata_nxt = word_v[p];
					rresp_nxt = hub_port_pkg::RESP_OKAY;
				end
				if (8'(s_axi_araddr) == word_ofs(hub_port_pkg::OFS_MASK_BASE, p)) begin
					rdata_nxt[hub_port_pkg::B_CHG_MSB:hub_port_pkg::B_CHG_LSB] = mask_r[p];
					rresp_nxt = hub_port_pkg::RESP_OKAY;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= 2'h0;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
			rresp_r  <= rresp_nxt;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;

	// Checks per port
	for (genvar g = 0; g < NPORT; g++) begin : g_chk
		chk_power_set_on: assert property (@(posedge clk) disable iff (!arst_n)
			(port_w[g][8] && !port_w[g][9] && !host_reset_state) |=> (power_r[g] && word_v[g][8]))
			else $error("power set write ignored");
		chk_always_on_read: assert property (@(posedge clk) disable iff (!arst_n)
			always_on |-> (word_v[g][8] && port_power_on[g]))
			else $error("always-on power not reading one");
		chk_slow_attached: assert property (@(posedge clk) disable iff (!arst_n)
			word_v[g][9] |-> (sync2_r[g].attached && sync2_r[g].slow))
			else $error("slow flag without attached device");
		chk_power_clear_off: assert property (@(posedge clk) disable iff (!arst_n)
			(port_w[g][9] && !always_on) |=> !power_r[g] && !port_power_on[g])
			else $error("power clear write ignored");
		chk_attach_change: assert property (@(posedge clk) disable iff (!arst_n)
			($changed(sync2_r[g].attached) && !host_reset_state) |=> chg_r[g][0])
			else $error("attach change not flagged");
		chk_host_fixed_attach: assert property (@(posedge clk) disable iff (!arst_n)
			host_reset_state |=> (chg_r[g][0] == $past(cfg_r[1 + g])))
			else $error("attach change reset value wrong");
		chk_enable_drop_set: assert property (@(posedge clk) disable iff (!arst_n)
			(port_evt[g].enable_drop && !host_reset_state) |=> chg_r[g][1])
			else $error("enable drop not flagged");
		chk_resume_done_set: assert property (@(posedge clk) disable iff (!arst_n)
			(port_evt[g].resume_done && !host_reset_state) |=> chg_r[g][2])
			else $error("resume done not flagged");
		chk_overload_change: assert property (@(posedge clk) disable iff (!arst_n)
			($changed(sync2_r[g].overload) && !host_reset_state) |=> chg_r[g][3])
			else $error("overload change not flagged");
		chk_reset_done_set: assert property (@(posedge clk) disable iff (!arst_n)
			(port_evt[g].reset_done && !host_reset_state) |=> chg_r[g][4])
			else $error("reset done not flagged");
		chk_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
			(word_v[g] & hub_port_pkg::PORT_RSVD) == 32'h0000_0000)
			else $error("reserved bits not zero");
		chk_flag_w1c: assert property (@(posedge clk) disable iff (!arst_n)
			(port_w[g][20] && !port_evt[g].reset_done) |=> !chg_r[g][4])
			else $error("reset done flag not cleared");
		chk_host_reset_word: assert property (@(posedge clk) disable iff (!arst_n)
			host_reset_state |=> (!power_r[g] && chg_r[g][4:1] == 4'h0 && cmd_r[g] == 5'h00))
			else $error("host reset left state");
		chk_disable_cmd: assert property (@(posedge clk) disable iff (!arst_n)
			(port_w[g][0] && !host_reset_state) |=> lower_cmd[g][0] ##1 !lower_cmd[g][0])
			else $error("disable command not issued");
	end
endmodule

//--- verilog/hub_port_pkg.sv
// Purpose: Shared constants and carriers for the root hub port status block
// Assumes: 32-bit AXI4-Lite data, byte addresses in the low address bits
// Notes:   Port words sit one word apart, mask words likewise
package hub_port_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CFG       = 8'h48;
	localparam logic [7:0] OFS_PORT_BASE = 8'h54;
	localparam logic [7:0] OFS_MASK_BASE = 8'h60;
	localparam logic [7:0] OFS_STEP      = 8'h04;

	// Port word field positions
	localparam int B_ATTACH   = 0;
	localparam int B_LOW_LSB  = 1;
	localparam int B_LOW_MSB  = 4;
	localparam int B_PWR      = 8;
	localparam int B_PWR_CLR  = 9;
	localparam int B_SLOW     = 9;
	localparam int B_CHG_LSB  = 16;
	localparam int B_CHG_MSB  = 20;
	localparam int CMD_W      = 5;
	localparam int CHG_W      = 5;

	// Change flag indices inside the change field
	localparam int C_ATTACH   = 0;
	localparam int C_EN_DROP  = 1;
	localparam int C_RESUME   = 2;
	localparam int C_OVL      = 3;
	localparam int C_RST_DONE = 4;

	// Configuration word fields
	localparam int CFG_ALWAYS_ON = 0;
	localparam int CFG_FIXED_LSB = 1;
	localparam int CFG_W         = 3;

	// Reserved bits of a port word, always zero
	localparam logic [31:0] PORT_RSVD = 32'hFFE0_FCE0;
	localparam logic [31:0] WORD_RST  = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Pins of one port, from outside the clock domain
	typedef struct packed {
		logic attached;
		logic slow;
		logic overload;
	} port_pins_s;

	// Same-clock events and lower status bits of one port
	typedef struct packed {
		logic       enable_drop;
		logic       resume_done;
		logic       reset_done;
		logic [3:0] lower;
	} port_evt_s;
endpackage

//--- tb/usb_dev_model.sv
// Purpose: Downstream device model sitting on one root hub port
// Assumes: Only pin levels matter; no packet traffic is modelled
// Notes:   Speed line falls low when unplugged, as its pull-down would hold it
`timescale 1ns/1ps
module usb_dev_model (
	input  wire logic                plug,
	input  wire logic                low_speed,
	input  wire logic                fault,
	output hub_port_pkg::port_pins_s pins
);
	// Pins follow the device; speed only means something while plugged
	assign pins = '{attached: plug, slow: plug & low_speed, overload: fault};
endmodule

//--- tb/tb_root_hub_port_status_upper.sv
// Purpose: Self-checking bench for the root hub port status block
// Assumes: Bus answers come when they come; the watchdog bounds every wait
// Notes:   Register rows first, then pin, event and host reset cases
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_root_hub_port_status_upper;
	localparam logic [7:0] P0 = hub_port_pkg::OFS_PORT_BASE;
	localparam logic [7:0] P1 = P0 + hub_port_pkg::OFS_STEP;
	localparam logic [7:0] CF = hub_port_pkg::OFS_CFG;
	typedef struct { logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex; } row_s;
	logic                      clk = 0, arst_n = 0, hrst = 0;
	logic [7:0]                awaddr = 0, araddr = 0;
	logic                      awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0]               wdata = 0, rdata, rd;
	logic                      awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]                bresp, rresp, rs, bs, pwr;
	logic [1:0]                plug = 0, low = 0, ovl = 0;
	hub_port_pkg::port_pins_s  pins [2];
	hub_port_pkg::port_evt_s   evt [2] = '{default: '0};
	logic [4:0]                lcmd [2];
	logic [4:0]                seen0 = 0, seen1 = 0;
	int                        fails = 0, n_tests = 0;
	row_s rows [7] = '{'{P0, 32'h100, P0, 32'h100}, '{P0, 32'h0, P0, 32'h100},
		'{P0, 32'hFFE0_FCE0, P0, 32'h100}, '{P0, 32'h200, P0, 32'h0},
		'{P1, 32'h100, P1, 32'h100}, '{CF, 32'h1, P0, 32'h100}, '{CF, 32'h0, P0, 32'h0}};

	// Free-running 20 MHz clock
	initial begin
		forever #25 clk = ~clk;
	end

	root_hub_port_status_upper uut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .host_reset_state(hrst), .port_pins(pins),
		.port_evt(evt), .port_power_on(pwr), .lower_cmd(lcmd), .irq(irq));
	usb_dev_model dev0 (.plug(plug[0]), .low_speed(low[0]), .fault(ovl[0]), .pins(pins[0]));
	usb_dev_model dev1 (.plug(plug[1]), .low_speed(low[1]), .fault(ovl[1]), .pins(pins[1]));

	// Keep the last command pulse, it lasts only one cycle
	always @(posedge clk) begin
		if (lcmd[0] !== 5'h00) seen0 <= lcmd[0];
		if (lcmd[1] !== 5'h00) seen1 <= lcmd[1];
	end

	// Both halves offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) break;
		end
		bs = bresp;
		bready <= 0;
	endtask

	task automatic rdw(input logic [7:0] a);
		@(posedge clk);
		araddr <= a; arvalid <= 1; rready <= 1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) break;
		end
		rd = rdata; rs = rresp; rready <= 0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
		rdw(a);
		`CHK(nm, ex, rd)
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Hang guard, far beyond the 125 or so cycles needed
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		end_of_test;
	end

	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1;
		rchk(P0, 32'h0, "reset word");
		`CHK("read resp", hub_port_pkg::RESP_OKAY, rs)
		`CHK("reset irq", 1'b0, irq)
		// Table rows: write one word, read the same word or another back
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			`CHK("row wr resp", hub_port_pkg::RESP_OKAY, bs)
			rchk(rows[i].ra, rows[i].ex, "row");
		end
		`CHK("power pins", 2'b10, pwr)
		// Slow device plugged in with an overload on port 0
		@(posedge clk);
		plug <= 2'h1; low <= 2'h1; ovl <= 2'h1;
		repeat (6) @(posedge clk);
		rchk(P0, 32'h0009_0201, "attach");
		wr(P0, 32'h0001_0000);
		rchk(P0, 32'h0008_0201, "attach w1c");
		wr(hub_port_pkg::OFS_MASK_BASE, 32'h0008_0000);
		repeat (2) @(posedge clk);
		`CHK("irq on", 1'b1, irq)
		wr(P0, 32'h0008_0001);
		rchk(P0, 32'h0000_0201, "ovl w1c");
		`CHK("irq off", 1'b0, irq)
		`CHK("disable cmd", 5'h01, seen0)
		// One-cycle hardware events on port 1
		@(posedge clk);
		evt[1] <= '{1'b1, 1'b1, 1'b1, 4'h0};
		@(posedge clk);
		evt[1] <= '0;
		rchk(P1, 32'h0016_0100, "events");
		wr(P1, 32'h0016_001F);
		rchk(P1, 32'h0000_0100, "events w1c");
		`CHK("port1 cmd", 5'h1F, seen1)
		rdw(8'h10);
		`CHK("unmapped data", 32'h0, rd)
		`CHK("unmapped resp", hub_port_pkg::RESP_SLVERR, rs)
		wr(8'h10, 32'hFFFF_FFFF);
		`CHK("unmapped wr resp", hub_port_pkg::RESP_SLVERR, bs)
		// Host reset with port 0 marked as fixed
		wr(CF, 32'h2);
		@(posedge clk);
		hrst <= 1;
		@(posedge clk);
		hrst <= 0;
		repeat (2) @(posedge clk);
		rchk(P0, 32'h0001_0201, "fixed reset");
		rchk(P1, 32'h0, "host reset");
		`CHK("power after", 2'b00, pwr)
		end_of_test;
	end
endmodule
